// ---- verilog/timer16_pwm.sv ----
//
// Overview of operation
// - fast mode: overflow flag at TOP
// - fast mode: TOP-source flag with overflow
// - fixed TOP masks compare write bits
// - unbuffered capture TOP may wrap past
// - fast mode: compare A loads at TOP
// - fast: clear on match, set at wrap
// - fast period is TOP+1 prescaled ticks
// - fast extremes: spike or constant level
// - channel A toggles on each match
// - dual slope count for selects 1,2,3,10,11
// - dual slope TOP by select value
// - TOP held one tick, then down
// - dual slope overflow flag at BOTTOM
// - dual slope buffers load at TOP
// - clear on up match, set down
// - output changes on both slope matches
// - dual slope period is twice TOP
// - dual slope extremes hold constant level
// - down slope old TOP, up new
// - fast mode selects 5,6,7,14,15 with TOP
// - action zero leaves output untouched
// - tick is an enable on one clock
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module timer16_pwm
    import timer16_pwm_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             WAVE_A_OUT,
    output logic             WAVE_A_OE_N,
    output logic             WAVE_B_OUT,
    output logic             WAVE_B_OE_N
);
    logic          rst_meta_q;
    logic          rst_n;
    logic [12:0]   ctrl_q;
    logic [15:0]   capt_q;
    logic [15:0]   cnt_q;
    logic [15:0]   cnt_d;
    logic [9:0]    pre_q;
    logic [3:0]    flag_q;
    logic [3:0]    flag_d;
    logic [31:0]   prdata_q;
    slope_t        slope_q;
    slope_t        slope_d;
    logic [15:0]   ocr_buf_q [2];
    logic [15:0]   ocr_act_q [2];
    logic [1:0]    wave_q;
    logic [1:0]    pin_q;
    logic [1:0]    oe_n_q;
    logic [1:0]    match;
    logic [1:0]    dir;
    logic [1:0]    act [2];

    // reset release through two stages
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // bus decode
    wire       setup    = PSEL & ~PENABLE;
    wire       wr_en    = PSEL & PENABLE & PWRITE;
    wire       hit      = PADDR == ADDR_CTRL || PADDR == ADDR_CMPA
                       || PADDR == ADDR_CMPB || PADDR == ADDR_CAPT
                       || PADDR == ADDR_CNT  || PADDR == ADDR_FLAG;
    wire       ctrl_wr  = wr_en & (PADDR == ADDR_CTRL);
    wire       capt_wr  = wr_en & (PADDR == ADDR_CAPT);
    wire       cnt_wr   = wr_en & (PADDR == ADDR_CNT);
    wire       flag_wr  = wr_en & (PADDR == ADDR_FLAG);
    wire [1:0] cmp_wr   = {wr_en & (PADDR == ADDR_CMPB),
                           wr_en & (PADDR == ADDR_CMPA)};
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit;
    assign PRDATA  = prdata_q;

    // control field decode
    wire [3:0] wsel     = ctrl_q[WSEL_LSB +: 4];
    wire [2:0] pre_sel  = ctrl_q[PRE_LSB +: 3];
    assign act[0] = ctrl_q[ACTA_LSB +: 2];
    assign act[1] = ctrl_q[ACTB_LSB +: 2];
    assign dir    = {ctrl_q[DIRB_BIT], ctrl_q[DIRA_BIT]};

    wire is_fast = wsel == WS_FP8 || wsel == WS_FP9 || wsel == WS_FP10
                || wsel == WS_FP_CAPT || wsel == WS_FP_CMPA;
    wire is_pc   = wsel == WS_PC8 || wsel == WS_PC9 || wsel == WS_PC10
                || wsel == WS_PC_CAPT || wsel == WS_PC_CMPA;
    wire pwm_on      = is_fast | is_pc;
    wire fixed_mode  = pwm_on & ~wsel[3];
    wire top_by_cmpa = pwm_on & wsel[3] & wsel[0];
    wire top_by_capt = pwm_on & wsel[3] & ~wsel[0];

    wire [15:0] fixed_top = (wsel[1:0] == RES_8) ? TOP8
                          : (wsel[1:0] == RES_9) ? TOP9 : TOP10;
    wire [15:0] top_w     = fixed_mode ? fixed_top
                          : (wsel[0] ? ocr_act_q[0] : capt_q);
    wire [15:0] wr_mask   = fixed_mode ? fixed_top : MAXV;
    wire [15:0] cmp_wdata = PWDATA[15:0] & wr_mask;

    wire [9:0] div_m1 = (pre_sel == PRE_SEL1)   ? DIV1_M1
                      : (pre_sel == PRE_SEL8)   ? DIV8_M1
                      : (pre_sel == PRE_SEL64)  ? DIV64_M1
                      : (pre_sel == PRE_SEL256) ? DIV256_M1 : DIV1024_M1;
    wire       run    = pre_sel != PRE_STOP;
    wire       tick   = run & (pre_q >= div_m1);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else begin
            pre_q <= (tick | ~run) ? '0 : pre_q + PRE_ONE;
        end
    end

    // counter stepping
    wire at_top  = cnt_q == top_w;
    wire at_bot  = cnt_q == BOTTOM;
    wire is_up   = slope_q == ST_UP;
    wire pc_top  = tick & is_pc & is_up & at_top;
    wire pc_bot  = tick & is_pc & ~is_up & at_bot;
    wire fp_top  = tick & is_fast & at_top;
    wire go_down = is_pc & (is_up ? at_top : ~at_bot);
    wire [15:0] cnt_inc = cnt_q + CNT_ONE;
    wire [15:0] cnt_dec = cnt_q - CNT_ONE;
    // capture TOP below count wraps via MAX
    wire [15:0] cnt_step = (is_fast & at_top) ? BOTTOM
                         : (go_down ? cnt_dec : cnt_inc);
    assign cnt_d = cnt_wr ? PWDATA[15:0]
                 : ((tick & pwm_on) ? cnt_step : cnt_q);

    always_comb begin
        slope_d = slope_q;
        case (slope_q)
            ST_UP:   if (pc_top) slope_d = ST_DOWN;
            ST_DOWN: if (pc_bot | ~is_pc) slope_d = ST_UP;
            default: slope_d = ST_UP;
        endcase
    end

    wire update_ev = fp_top | pc_top;
    wire ovf_ev    = fp_top | pc_bot;
    wire capt_ev   = update_ev & top_by_capt;
    wire cmpa_ev   = match[0] | (update_ev & top_by_cmpa);
    wire [3:0] set_v = {capt_ev, match[1], cmpa_ev, ovf_ev};
    wire [3:0] clr_v = flag_wr ? PWDATA[3:0] : 4'h0;
    // set wins over a same-cycle clear
    assign flag_d = (flag_q & ~clr_v) | set_v;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= CTRL_RST;
            capt_q  <= BOTTOM;
            cnt_q   <= BOTTOM;
            flag_q  <= 4'h0;
            slope_q <= ST_UP;
        end else begin
            if (ctrl_wr)
                ctrl_q <= PWDATA[CTRL_W-1:0];
            if (capt_wr)
                capt_q <= PWDATA[15:0];
            cnt_q   <= cnt_d;
            flag_q  <= flag_d;
            slope_q <= slope_d;
        end
    end

    // read data sampled in setup phase
    wire [31:0] rd_mux =
        (PADDR == ADDR_CTRL) ? {19'h0, ctrl_q}
      : (PADDR == ADDR_CMPA) ? {16'h0, ocr_buf_q[0]}
      : (PADDR == ADDR_CMPB) ? {16'h0, ocr_buf_q[1]}
      : (PADDR == ADDR_CAPT) ? {16'h0, capt_q}
      : (PADDR == ADDR_CNT)  ? {16'h0, cnt_q}
      : (PADDR == ADDR_FLAG) ? {27'h0, slope_q == ST_DOWN, flag_q}
      : 32'h0;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

    // bottom counts as up, TOP as down, for dual slope extremes
    wire up_eff = at_bot | (is_up & ~at_top);

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            wire pol    = act[i] == ACT_INV;
            wire pwm_a  = act[i][1];
            wire toggle = (i == 0) && act[i] == ACT_TOGGLE;
            assign match[i] = tick & pwm_on & (cnt_q == ocr_act_q[i]);

            // buffer only while a PWM mode is selected, even with the prescaler stopped
            always_ff @(posedge CORE_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    ocr_buf_q[i] <= BOTTOM;
                    ocr_act_q[i] <= BOTTOM;
                end else begin
                    if (cmp_wr[i])
                        ocr_buf_q[i] <= cmp_wdata;
                    if (update_ev)
                        ocr_act_q[i] <= ocr_buf_q[i];
                    else if (cmp_wr[i] & ~pwm_on)
                        ocr_act_q[i] <= cmp_wdata;
                end
            end

            always_ff @(posedge CORE_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    wave_q[i] <= 1'b0;
                end else if (fp_top & pwm_a) begin
                    wave_q[i] <= ~pol;
                end else if (match[i] & pwm_a & is_fast) begin
                    wave_q[i] <= pol;
                end else if (match[i] & pwm_a & is_pc) begin
                    wave_q[i] <= up_eff ? pol : ~pol;
                end else if (match[i] & toggle) begin
                    wave_q[i] <= ~wave_q[i];
                end
            end

            always_ff @(posedge CORE_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    pin_q[i]  <= 1'b0;
                    oe_n_q[i] <= 1'b1;
                end else begin
                    pin_q[i]  <= wave_q[i] & dir[i];
                    oe_n_q[i] <= ~dir[i];
                end
            end
        end
    endgenerate

    assign WAVE_A_OUT  = pin_q[0];
    assign WAVE_A_OE_N = oe_n_q[0];
    assign WAVE_B_OUT  = pin_q[1];
    assign WAVE_B_OE_N = oe_n_q[1];

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    a_fast_ovf_top: assert property (
        fp_top |=> flag_q[FLG_OVF]) else $error("no overflow at TOP");
    a_capt_with_ovf: assert property (
        fp_top && top_by_capt |=> flag_q[FLG_CAPT] && flag_q[FLG_OVF])
        else $error("capture flag not with overflow");
    a_cmp_mask: assert property (
        cmp_wr[0] && fixed_mode |=> (ocr_buf_q[0] & ~$past(fixed_top)) == 0)
        else $error("compare bits not masked");
    a_capt_wrap: assert property (
        tick && is_fast && cnt_q == MAXV && capt_q != MAXV && !cnt_wr
        |=> cnt_q == BOTTOM) else $error("no wrap past MAX");
    a_buf_load: assert property (
        update_ev |=> ocr_act_q[0] == $past(ocr_buf_q[0]))
        else $error("buffer not loaded at TOP");
    a_fast_set_wrap: assert property (
        fp_top && act[0] == ACT_NONINV |=> wave_q[0])
        else $error("output not set at wrap");
    a_pc_turn: assert property (
        pc_top && !cnt_wr |=> slope_q == ST_DOWN && cnt_q == $past(cnt_dec))
        else $error("no reversal after TOP");
    a_pc_ovf_bot: assert property (
        pc_bot |=> flag_q[FLG_OVF]) else $error("no overflow at BOTTOM");
    a_pc_up_clear: assert property (
        match[0] && is_pc && up_eff && act[0] == ACT_NONINV |=> !wave_q[0])
        else $error("no clear on up match");
    a_act_none: assert property (
        act[0] == ACT_NONE |=> wave_q[0] == $past(wave_q[0]))
        else $error("output moved with action zero");
    a_tick_div8: assert property (
        (tick && pre_sel == PRE_SEL8 && !ctrl_wr) ##1 (!ctrl_wr)[*7]
        |=> tick) else $error("tick spacing wrong");
    a_pin_gated: assert property (
        !dir[0] |=> !WAVE_A_OUT && WAVE_A_OE_N)
        else $error("pin driven without direction");

    c_fast_wrap: cover property (fp_top && act[0] == ACT_NONINV);
    c_pc_top:    cover property (pc_top ##[1:1000] pc_bot);
    c_toggle:    cover property (match[0] && act[0] == ACT_TOGGLE);
    c_capt_flag: cover property (capt_ev);
endmodule : timer16_pwm

// ---- verilog/timer16_pwm_pkg.sv ----
package timer16_pwm_pkg;
    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_CMPA  = 8'h04;
    localparam logic [7:0]  ADDR_CMPB  = 8'h08;
    localparam logic [7:0]  ADDR_CAPT  = 8'h0C;
    localparam logic [7:0]  ADDR_CNT   = 8'h10;
    localparam logic [7:0]  ADDR_FLAG  = 8'h14;
    // control fields
    localparam int          CTRL_W     = 13;
    localparam int          WSEL_LSB   = 0;
    localparam int          ACTA_LSB   = 4;
    localparam int          ACTB_LSB   = 6;
    localparam int          PRE_LSB    = 8;
    localparam int          DIRA_BIT   = 11;
    localparam int          DIRB_BIT   = 12;
    localparam logic [12:0] CTRL_RST   = 13'h0000;
    // flag bits, slope bit is read only
    localparam int          FLG_OVF    = 0;
    localparam int          FLG_CMPA   = 1;
    localparam int          FLG_CMPB   = 2;
    localparam int          FLG_CAPT   = 3;
    localparam int          FLG_DOWN   = 4;
    // waveform select encodings
    localparam logic [3:0]  WS_PC8     = 4'h1;
    localparam logic [3:0]  WS_PC9     = 4'h2;
    localparam logic [3:0]  WS_PC10    = 4'h3;
    localparam logic [3:0]  WS_PC_CAPT = 4'hA;
    localparam logic [3:0]  WS_PC_CMPA = 4'hB;
    localparam logic [3:0]  WS_FP8     = 4'h5;
    localparam logic [3:0]  WS_FP9     = 4'h6;
    localparam logic [3:0]  WS_FP10    = 4'h7;
    localparam logic [3:0]  WS_FP_CAPT = 4'hE;
    localparam logic [3:0]  WS_FP_CMPA = 4'hF;
    localparam logic [1:0]  RES_8      = 2'h1;
    localparam logic [1:0]  RES_9      = 2'h2;
    localparam logic [15:0] TOP8       = 16'h00FF;
    localparam logic [15:0] TOP9       = 16'h01FF;
    localparam logic [15:0] TOP10      = 16'h03FF;
    localparam logic [15:0] BOTTOM     = 16'h0000;
    localparam logic [15:0] MAXV       = 16'hFFFF;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    // output actions
    localparam logic [1:0]  ACT_NONE   = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  ACT_NONINV = 2'h2;
    localparam logic [1:0]  ACT_INV    = 2'h3;
    // prescale select and divide-minus-one values
    localparam logic [2:0]  PRE_STOP   = 3'h0;
    localparam logic [2:0]  PRE_SEL1   = 3'h1;
    localparam logic [2:0]  PRE_SEL8   = 3'h2;
    localparam logic [2:0]  PRE_SEL64  = 3'h3;
    localparam logic [2:0]  PRE_SEL256 = 3'h4;
    localparam logic [9:0]  DIV1_M1    = 10'h000;
    localparam logic [9:0]  DIV8_M1    = 10'h007;
    localparam logic [9:0]  DIV64_M1   = 10'h03F;
    localparam logic [9:0]  DIV256_M1  = 10'h0FF;
    localparam logic [9:0]  DIV1024_M1 = 10'h3FF;
    localparam logic [9:0]  PRE_ONE    = 10'h001;
    typedef enum logic [1:0] {ST_UP = 2'b01, ST_DOWN = 2'b10} slope_t;
endpackage : timer16_pwm_pkg

// ---- sim/wave_pin_monitor.sv ----
`timescale 1ns/10ps
module wave_pin_monitor (
    input  wire logic        clk,
    input  wire logic        wave_out,
    input  wire logic        wave_oe_n,
    output logic             pin,
    output logic      [31:0] last_period,
    output logic      [31:0] last_high,
    output logic      [31:0] rises
);
    logic        pin_q;
    logic [31:0] since;
    logic [31:0] hi;
    assign pin = wave_oe_n ? 1'b0 : wave_out;
    initial begin
        pin_q       = 1'b0;
        since       = 32'h0;
        hi          = 32'h0;
        last_period = 32'h0;
        last_high   = 32'h0;
        rises       = 32'h0;
    end
    // period and high time between rising edges
    always @(posedge clk) begin
        pin_q <= pin;
        if (pin && !pin_q) begin
            last_period <= since;
            last_high   <= hi;
            since       <= 32'h1;
            hi          <= 32'h1;
            rises       <= rises + 32'h1;
        end else begin
            since <= since + 32'h1;
            hi    <= hi + {31'h0, pin};
        end
    end
endmodule : wave_pin_monitor

// ---- sim/timer16_fast_and_phase_pwm_bench.sv ----
`timescale 1ns/10ps
module timer16_fast_and_phase_pwm_bench;
    import timer16_pwm_pkg::*;
    logic        CORE_CLK = 1'b0;
    logic        RSTN     = 1'b0;
    logic        PSEL     = 1'b0;
    logic        PENABLE  = 1'b0;
    logic        PWRITE   = 1'b0;
    logic [7:0]  PADDR    = 8'h00;
    logic [31:0] PWDATA   = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        WAVE_A_OUT;
    logic        WAVE_A_OE_N;
    logic        pin;
    logic        err;
    logic [31:0] per;
    logic [31:0] hig;
    logic [31:0] rises;
    logic [31:0] rd;
    int          errors     = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    timer16_pwm dut_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .WAVE_A_OUT(WAVE_A_OUT), .WAVE_A_OE_N(WAVE_A_OE_N),
        .WAVE_B_OUT(), .WAVE_B_OE_N());
    wave_pin_monitor mon_u (.clk(CORE_CLK), .wave_out(WAVE_A_OUT),
        .wave_oe_n(WAVE_A_OE_N), .pin(pin), .last_period(per),
        .last_high(hig), .rises(rises));

    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    task final_report;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // hang guard, well above the longest expected run
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            errors = errors + 1;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'b1) @(posedge CORE_CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    function logic [31:0] ctl(logic [3:0] ws, logic [1:0] act,
                              logic [2:0] pre, logic dir);
        return 32'({dir, pre, 2'h0, act, ws});
    endfunction : ctl

    function int per_exp(logic [3:0] ws, int top, logic [1:0] act);
        int p;
        p = (ws inside {WS_FP8, WS_FP9, WS_FP10, WS_FP_CAPT, WS_FP_CMPA})
            ? top + 1 : 2 * top;
        return (act == ACT_TOGGLE) ? 2 * p : p;
    endfunction : per_exp

    function int hi_exp(logic [3:0] ws, int top, int cmp, logic [1:0] act);
        if (act == ACT_TOGGLE)
            return top + 1;
        if (ws inside {WS_FP8, WS_FP9, WS_FP10, WS_FP_CAPT})
            return (act == ACT_NONINV) ? cmp + 1 : top - cmp;
        return (act == ACT_NONINV) ? 2 * cmp : 2 * (top - cmp);
    endfunction : hi_exp

    // counter parked while top and compare are loaded
    task setup(input logic [3:0] ws, input logic [15:0] top, cmp,
               input logic [1:0] act, input logic [2:0] pre);
        apb(1'b1, ADDR_CTRL, ctl(ws, act, PRE_STOP, 1'b1));
        apb(1'b1, ADDR_CAPT, 32'(top));
        apb(1'b1, ADDR_CMPA, 32'(cmp));
        apb(1'b1, ADDR_CNT, 32'h0);
        apb(1'b1, ADDR_CTRL, ctl(ws, act, pre, 1'b1));
    endtask : setup

    task wait_rises(input int n);
        logic [31:0] r0;
        r0 = rises;
        while (rises - r0 < n) @(posedge CORE_CLK);
    endtask : wait_rises

    task run(input logic [3:0] ws, input logic [15:0] top, cmp,
             input logic [1:0] act, input logic [2:0] pre, input int m);
        logic [31:0] fl;
        setup(ws, top, cmp, act, pre);
        wait_rises(3);
        chk("period", per, 32'(m * per_exp(ws, top, act)));
        chk("high", hig, 32'(m * hi_exp(ws, top, cmp, act)));
        apb(1'b1, ADDR_FLAG, 32'h1F);
        wait_rises(2);
        // compare B idles at zero, so it matches every period too
        fl = (ws == WS_FP_CAPT || ws == WS_PC_CAPT) ? 32'hF : 32'h7;
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("flags", rd & 32'hF, fl);
    endtask : run

    task steady(input logic [3:0] ws, input logic [15:0] cmp,
                input logic [1:0] act, input logic lvl);
        logic [31:0] r0;
        setup(ws, 16'h9, cmp, act, PRE_SEL1);
        repeat (60) @(posedge CORE_CLK);
        r0 = rises;
        repeat (60) @(posedge CORE_CLK);
        chk("no edges", rises, r0);
        if (act != ACT_NONE)
            chk("level", 32'(pin), 32'(lvl));
    endtask : steady

    logic [3:0]  fx [6] = '{WS_FP8, WS_FP9, WS_FP10, WS_PC8, WS_PC9, WS_PC10};
    logic [15:0] tp [6] = '{TOP8, TOP9, TOP10, TOP8, TOP9, TOP10};
    logic [15:0] top;
    logic [15:0] cmp;
    logic        pre8;

    initial begin
        void'($urandom(76));
        repeat (4) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'(CTRL_RST));
        chk("oe reset", 32'(WAVE_A_OE_N), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ADDR_CTRL, ctl(fx[i], ACT_NONE, PRE_STOP, 1'b0));
            apb(1'b1, ADDR_CMPA, 32'hFFFF);
            apb(1'b0, ADDR_CMPA, 32'h0);
            chk("masked compare", rd, 32'(tp[i]));
        end
        for (int i = 0; i < 6; i++)
            run(fx[i], tp[i], 16'h40, ACT_NONINV, PRE_SEL1, 1);
        for (int i = 0; i < 6; i++) begin
            top  = 16'(3 + $urandom % 38);
            cmp  = 16'(1 + $urandom % (top - 1));
            pre8 = 1'($urandom % 2);
            run(($urandom % 2) ? WS_FP_CAPT : WS_PC_CAPT, top, cmp,
                ($urandom % 2) ? ACT_NONINV : ACT_INV,
                pre8 ? PRE_SEL8 : PRE_SEL1, pre8 ? 8 : 1);
        end
        run(WS_FP_CAPT, 16'h9, 16'h0, ACT_NONINV, PRE_SEL1, 1);
        run(WS_FP_CMPA, 16'h5, 16'h5, ACT_TOGGLE, PRE_SEL1, 1);
        apb(1'b1, ADDR_CMPA, 32'h7);
        wait_rises(3);
        chk("new top period", per, 32'h10);
        chk("new top high", hig, 32'h8);
        steady(WS_FP_CAPT, 16'h9, ACT_NONINV, 1'b1);
        steady(WS_FP_CAPT, 16'h9, ACT_INV, 1'b0);
        steady(WS_PC_CAPT, 16'h0, ACT_NONINV, 1'b0);
        steady(WS_PC_CAPT, 16'h9, ACT_NONINV, 1'b1);
        steady(WS_PC_CAPT, 16'h0, ACT_INV, 1'b1);
        steady(WS_FP_CAPT, 16'h4, ACT_NONE, 1'b0);
        // unbuffered top written below the running count
        setup(WS_FP_CAPT, 16'hC8, 16'h32, ACT_NONINV, PRE_SEL1);
        wait_rises(1);
        repeat (60) @(posedge CORE_CLK);
        apb(1'b1, ADDR_CAPT, 32'hA);
        apb(1'b0, ADDR_CNT, 32'h0);
        chk("count past top", 32'(rd[15:0] > 16'hA), 32'h1);
        apb(1'b1, ADDR_CTRL, ctl(WS_FP_CAPT, ACT_NONINV, PRE_SEL1, 1'b0));
        repeat (4) @(posedge CORE_CLK);
        chk("oe off", 32'(WAVE_A_OE_N), 32'h1);
        chk("pin off", 32'(WAVE_A_OUT), 32'h0);
        final_report();
    end
endmodule : timer16_fast_and_phase_pwm_bench
